// File: include/ptc_pkg.sv
/*
 Constants, types and register map of the PHY test and configuration control block.
 Assumes a single 250 MHz clock and an AXI4-Lite master on the register side.
*/
package ptc_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned SOFT_RST_NS = 1000;
   localparam int unsigned SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ) / 1000;
   localparam int unsigned GEN_FRAME_LIMIT = 30000000;
   localparam int unsigned FRAME_CNT_W = 25;

   localparam logic [4:0] REG_MODE_CTRL = 5'h00;
   localparam logic [4:0] REG_MODE_STAT = 5'h01;
   localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
   localparam logic [4:0] REG_MMD_DATA = 5'h0E;
   localparam logic [4:0] REG_BYPASS = 5'h12;
   localparam logic [4:0] REG_ERR_CNT = 5'h13;
   localparam logic [4:0] REG_EXT_STAT = 5'h16;
   localparam logic [4:0] REG_EXT_CTRL1 = 5'h17;
   localparam logic [4:0] REG_EXT_CTRL2 = 5'h18;
   localparam logic [4:0] REG_PAGE = 5'h1F;
   localparam logic [4:0] REG_GEN_CFG1 = 5'h1D;
   localparam logic [4:0] REG_GEN_CFG2 = 5'h1E;
   localparam logic [4:0] REG_RGMII_CTRL = 5'h14;

   localparam logic [15:0] PAGE_MAIN = 16'h0000;
   localparam logic [15:0] PAGE_EXT1 = 16'h0001;
   localparam logic [15:0] PAGE_EXT2 = 16'h0002;
   localparam logic [15:0] PAGE_GP = 16'h0010;

   localparam int unsigned MC_SOFT_RST = 15;
   localparam int unsigned MC_LOOPBACK = 14;
   localparam int unsigned MC_SPEED_LSB = 13;
   localparam int unsigned MC_ANEG = 12;
   localparam int unsigned MC_PWR_DOWN = 11;
   localparam int unsigned MC_ISOLATE = 10;
   localparam int unsigned MC_DUPLEX = 8;
   localparam int unsigned MC_SPEED_MSB = 6;
   localparam int unsigned MS_LINK = 2;
   localparam int unsigned EC1_FAR_LOOP = 3;
   localparam int unsigned EC1_MAC_MODE_LO = 11;
   localparam int unsigned EC2_CONN_LOOP = 0;
   localparam int unsigned BYP_PAIR_SWAP_OFF = 5;
   localparam int unsigned GEN_ENABLE = 15;
   localparam int unsigned GEN_TRANSMIT = 14;
   localparam int unsigned GEN_DURATION = 13;
   localparam int unsigned GEN_BAD_FCS = 12;
   localparam int unsigned GEN_GAP_LO = 8;
   localparam int unsigned RG_MODE_BIT = 11;
   localparam int unsigned RG_RX_DLY_LO = 4;
   localparam int unsigned RG_TX_DLY_LO = 0;
   localparam int unsigned MMD_FUNC_LO = 14;

   localparam logic [15:0] MODE_CTRL_RST = 16'h1040;
   localparam logic [15:0] MODE_STAT_RST = 16'h7800;
   localparam logic [15:0] ZERO_RST = 16'h0000;
   localparam logic [1:0] AXI_OKAY = 2'h0;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ptc_stream_s;

   typedef enum {
      R_NONE, R_MODE, R_STAT, R_MMDC, R_MMDD, R_BYP, R_ERR, R_XSTAT,
      R_XC1, R_XC2, R_PAGE, R_GEN1, R_GEN2, R_RGMII
   } ptc_reg_e;
endpackage : ptc_pkg

// File: verilog/ptc_sync2.sv
/*
 Two flip-flop synchroniser for one level.
 Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/1ps
module ptc_sync2 (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic async,
   output logic synced
);
   logic stage1;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= 1'b0;
         synced <= 1'b0;
      end else begin
         stage1 <= async;
         synced <= stage1;
      end
   end
endmodule : ptc_sync2

// File: verilog/ptc_frame_gen.sv
/*
 Built-in frame generator: header, pattern payload, check bytes, gap, frame count.
 Assumes run is a level from register logic on the same clock.
*/
`timescale 1ns/1ps
module ptc_frame_gen import ptc_pkg::*; #(
   parameter int unsigned FRAME_LIMIT = GEN_FRAME_LIMIT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [15:0] cfg1,
   input wire logic [15:0] cfg2,
   output ptc_stream_s txOut,
   output logic done
);
   logic runPrev;
   logic inGap;
   logic [3:0] gapCnt;
   logic [8:0] byteIdx;
   logic [FRAME_CNT_W-1:0] frameCnt;
   logic [8:0] lastIdx;

   // Frame is 6 destination, 6 source, payload of cfg1[7:0] bytes, 4 check bytes.
   assign lastIdx = 9'(cfg1[7:0]) + 9'h00F;

   function automatic logic [7:0] genByte(input logic [8:0] idx,
                                          input logic [15:0] c1,
                                          input logic [15:0] c2);
      logic [8:0] payEnd;
      payEnd = 9'(c1[7:0]) + 9'h00C;
      if (idx < 9'h006) genByte = c2[15:8];
      else if (idx < 9'h00C) genByte = ~c2[15:8];
      else if (idx < payEnd) genByte = c2[7:0];
      else if (c1[GEN_BAD_FCS]) genByte = ~(c2[7:0] ^ idx[7:0]);
      else genByte = c2[7:0] ^ idx[7:0];
   endfunction : genByte

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         runPrev <= 1'b0;
         inGap <= 1'b0;
         gapCnt <= 4'h0;
         byteIdx <= 9'h000;
         frameCnt <= '0;
         txOut <= '0;
         done <= 1'b0;
      end else begin
         runPrev <= run;
         done <= 1'b0;
         if (run && !runPrev) begin
            frameCnt <= '0;
            byteIdx <= 9'h000;
            inGap <= 1'b0;
            txOut <= '0;
         end else if (!run) begin
            txOut <= '0;
         end else if (inGap) begin
            txOut.valid <= 1'b0;
            if (gapCnt == 4'h0) inGap <= 1'b0;
            else gapCnt <= gapCnt - 4'h1;
         end else begin
            txOut.valid <= 1'b1;
            txOut.data <= genByte(byteIdx, cfg1, cfg2);
            if (byteIdx == lastIdx) begin
               byteIdx <= 9'h000;
               inGap <= 1'b1;
               gapCnt <= cfg1[GEN_GAP_LO +: 4];
               frameCnt <= frameCnt + 1'b1;
               if (!cfg1[GEN_DURATION] && frameCnt == FRAME_CNT_W'(FRAME_LIMIT - 1)) begin
                  done <= 1'b1;
               end
            end else begin
               byteIdx <= byteIdx + 9'h001;
            end
         end
      end
   end
endmodule : ptc_frame_gen

// File: verilog/ptc_test_ctrl.sv
/*
 Top of the PHY test and configuration control: paged register space over
 AXI4-Lite, data path steering for generator and loopbacks, hold-inactive pin.
 Assumes streams are on clk; the hold-inactive pin is asynchronous.
*/
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module ptc_test_ctrl import ptc_pkg::*; #(
   parameter int unsigned FRAME_LIMIT = GEN_FRAME_LIMIT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [6:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [6:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ptc_stream_s macTx,
   input wire ptc_stream_s mediaRx,
   output ptc_stream_s mediaTx,
   output ptc_stream_s macRx,
   input wire logic holdInactivePin,
   input wire logic linkUp,
   input wire logic rxSymbolErr,
   output logic phyActive,
   output logic [1:0] macMode,
   output logic [1:0] speedSel,
   output logic duplexFull,
   output logic anegEnable,
   output logic powerDown,
   output logic connLoopback1g,
   output logic pairSwapOff,
   output logic rgmiiModeBit,
   output logic [2:0] rxClkDelay,
   output logic [2:0] txClkDelay
);
   logic [15:0] modeCtrl;
   logic [15:0] extCtrl1;
   logic [15:0] extCtrl2;
   logic [15:0] bypassCtrl;
   logic [15:0] pageSel;
   logic [15:0] genCfg1;
   logic [15:0] genCfg2;
   logic [15:0] rgmiiCtrl;
   logic [15:0] mmdCtrl;
   logic [15:0] mmdAddr;
   logic [15:0] mmdData [0:3];
   logic [7:0] errCnt;
   logic errSeen;
   logic linkLatch;
   logic [7:0] softBusy;
   logic awHeld;
   logic wHeld;
   logic [4:0] awIdx;
   logic [15:0] wData;
   logic [1:0] wStrb;
   logic writeFire;
   logic readFire;
   logic softRstHit;
   logic holdSync;
   logic genDone;
   ptc_stream_s genOut;
   ptc_reg_e wSel;
   ptc_reg_e rSel;
   logic [15:0] merged;

   // Decodes an index against the page in force; 18 to 30 depend on it.
   function automatic ptc_reg_e regSel(input logic [4:0] idx, input logic [15:0] page);
      regSel = R_NONE;
      if (idx == REG_PAGE) regSel = R_PAGE;
      else if (idx == REG_MODE_CTRL) regSel = R_MODE;
      else if (idx == REG_MODE_STAT) regSel = R_STAT;
      else if (idx == REG_MMD_CTRL) regSel = R_MMDC;
      else if (idx == REG_MMD_DATA) regSel = R_MMDD;
      else if (page == PAGE_MAIN) begin
         unique case (idx)
            REG_BYPASS: regSel = R_BYP;
            REG_ERR_CNT: regSel = R_ERR;
            REG_EXT_STAT: regSel = R_XSTAT;
            REG_EXT_CTRL1: regSel = R_XC1;
            REG_EXT_CTRL2: regSel = R_XC2;
            default: regSel = R_NONE;
         endcase
      end else if (page == PAGE_EXT1) begin
         if (idx == REG_GEN_CFG1) regSel = R_GEN1;
         else if (idx == REG_GEN_CFG2) regSel = R_GEN2;
      end else if (page == PAGE_EXT2) begin
         if (idx == REG_RGMII_CTRL) regSel = R_RGMII;
      end
   endfunction : regSel

   // Applies the two low byte lanes of a write onto the stored value.
   function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                             input logic [15:0] nw,
                                             input logic [1:0] strb);
      laneMerge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction : laneMerge

   assign writeFire = awHeld && wHeld && !s_axi_bvalid;
   assign readFire = s_axi_arvalid && s_axi_arready;
   assign wSel = regSel(awIdx, pageSel);
   assign rSel = regSel(s_axi_araddr[6:2], pageSel);
   assign softRstHit = writeFire && wSel == R_MODE && merged[MC_SOFT_RST];

   always_comb begin
      unique case (wSel)
         R_MODE: merged = laneMerge(modeCtrl, wData, wStrb);
         R_MMDC: merged = laneMerge(mmdCtrl, wData, wStrb);
         R_MMDD: merged = laneMerge(mmdData[mmdAddr[1:0]], wData, wStrb);
         R_BYP: merged = laneMerge(bypassCtrl, wData, wStrb);
         R_XC1: merged = laneMerge(extCtrl1, wData, wStrb);
         R_XC2: merged = laneMerge(extCtrl2, wData, wStrb);
         R_PAGE: merged = laneMerge(pageSel, wData, wStrb);
         R_GEN1: merged = laneMerge(genCfg1, wData, wStrb);
         R_GEN2: merged = laneMerge(genCfg2, wData, wStrb);
         R_RGMII: merged = laneMerge(rgmiiCtrl, wData, wStrb);
         default: merged = laneMerge(ZERO_RST, wData, wStrb);
      endcase
   end

   // Write address and data are taken in either order and joined here.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIdx <= 5'h00;
         wData <= 16'h0000;
         wStrb <= 2'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awIdx <= s_axi_awaddr[6:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata[15:0];
            wStrb <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
         end
         if (writeFire) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data is registered on the same edge that takes the address.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= AXI_OKAY;
      end else if (readFire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         unique case (rSel)
            R_MODE: s_axi_rdata <= {16'h0000, softBusy != 8'h00, modeCtrl[14:0]};
            R_STAT: s_axi_rdata <= {16'h0000, MODE_STAT_RST[15:3], linkLatch, 2'h0};
            R_MMDC: s_axi_rdata <= {16'h0000, mmdCtrl};
            R_MMDD: s_axi_rdata <= {16'h0000, (mmdCtrl[MMD_FUNC_LO +: 2] == 2'h0) ?
                                    mmdAddr : mmdData[mmdAddr[1:0]]};
            R_BYP: s_axi_rdata <= {16'h0000, bypassCtrl};
            R_ERR: s_axi_rdata <= {24'h000000, errCnt};
            R_XSTAT: s_axi_rdata <= {31'h00000000, errSeen};
            R_XC1: s_axi_rdata <= {16'h0000, extCtrl1};
            R_XC2: s_axi_rdata <= {16'h0000, extCtrl2};
            R_PAGE: s_axi_rdata <= {16'h0000, pageSel};
            R_GEN1: s_axi_rdata <= {16'h0000, genCfg1};
            R_GEN2: s_axi_rdata <= {16'h0000, genCfg2};
            R_RGMII: s_axi_rdata <= {16'h0000, rgmiiCtrl};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Configuration registers; software reset restores all but mmdData, sticky status survives.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeCtrl <= MODE_CTRL_RST;
         extCtrl1 <= ZERO_RST;
         extCtrl2 <= ZERO_RST;
         bypassCtrl <= ZERO_RST;
         pageSel <= PAGE_MAIN;
         genCfg1 <= ZERO_RST;
         genCfg2 <= ZERO_RST;
         rgmiiCtrl <= ZERO_RST;
         mmdCtrl <= ZERO_RST;
         mmdAddr <= ZERO_RST;
         for (int i = 0; i < 4; i++) mmdData[i] <= ZERO_RST;
      end else if (softRstHit) begin
         modeCtrl <= MODE_CTRL_RST;
         extCtrl1 <= ZERO_RST;
         extCtrl2 <= ZERO_RST;
         bypassCtrl <= ZERO_RST;
         pageSel <= PAGE_MAIN;
         genCfg1 <= ZERO_RST;
         genCfg2 <= ZERO_RST;
         rgmiiCtrl <= ZERO_RST;
         mmdCtrl <= ZERO_RST;
         mmdAddr <= ZERO_RST;
      end else begin
         if (genDone) genCfg1[GEN_TRANSMIT] <= 1'b0;
         if (writeFire) begin
            unique case (wSel)
               R_MODE: modeCtrl <= {1'b0, merged[14:0]};
               R_MMDC: mmdCtrl <= merged;
               R_MMDD: begin
                  if (mmdCtrl[MMD_FUNC_LO +: 2] == 2'h0) mmdAddr <= merged;
                  else mmdData[mmdAddr[1:0]] <= merged;
               end
               R_BYP: bypassCtrl <= merged;
               R_XC1: extCtrl1 <= merged;
               R_XC2: extCtrl2 <= merged;
               R_PAGE: pageSel <= merged;
               R_GEN1: genCfg1 <= merged;
               R_GEN2: genCfg2 <= merged;
               R_RGMII: rgmiiCtrl <= merged;
               default: ;
            endcase
         end
      end
   end

   // Self-clearing software reset bit reads one for about a microsecond.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) softBusy <= 8'h00;
      else if (softRstHit) softBusy <= 8'(SOFT_RST_CYC);
      else if (softBusy != 8'h00) softBusy <= softBusy - 8'h01;
   end

   // Status: clear-on-read counter, latch-high error flag, latch-low link bit.
   // An event in the cycle of the clearing read is kept.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         errCnt <= 8'h00;
         errSeen <= 1'b0;
         linkLatch <= 1'b0;
      end else begin
         if (readFire && rSel == R_ERR) errCnt <= {7'h00, rxSymbolErr};
         else if (rxSymbolErr && errCnt != 8'hFF) errCnt <= errCnt + 8'h01;
         if (rxSymbolErr) errSeen <= 1'b1;
         else if (readFire && rSel == R_XSTAT) errSeen <= 1'b0;
         if (!linkUp) linkLatch <= 1'b0;
         else if (readFire && rSel == R_STAT) linkLatch <= 1'b1;
      end
   end

   ptc_sync2 u_holdSync (
      .clk(clk),
      .rst_b(rst_b),
      .async(holdInactivePin),
      .synced(holdSync)
   );

   ptc_frame_gen #(
      .FRAME_LIMIT(FRAME_LIMIT)
   ) u_gen (
      .clk(clk),
      .rst_b(rst_b),
      .run(genCfg1[GEN_ENABLE] && genCfg1[GEN_TRANSMIT] && phyActive),
      .cfg1(genCfg1),
      .cfg2(genCfg2),
      .txOut(genOut),
      .done(genDone)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) phyActive <= 1'b0;
      else phyActive <= !holdSync;
   end

   // Data path steering toward the media and toward the MAC.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mediaTx <= '0;
         macRx <= '0;
      end else if (!phyActive || modeCtrl[MC_PWR_DOWN]) begin
         mediaTx <= '0;
         macRx <= '0;
      end else begin
         if (modeCtrl[MC_LOOPBACK]) mediaTx <= '0;
         else if (extCtrl1[EC1_FAR_LOOP]) mediaTx <= mediaRx;
         else if (genCfg1[GEN_ENABLE]) mediaTx <= genOut;
         else mediaTx <= macTx;
         if (modeCtrl[MC_ISOLATE]) macRx <= '0;
         else if (modeCtrl[MC_LOOPBACK]) macRx <= macTx;
         else macRx <= mediaRx;
      end
   end

   assign macMode = extCtrl1[EC1_MAC_MODE_LO +: 2];
   assign speedSel = {modeCtrl[MC_SPEED_MSB], modeCtrl[MC_SPEED_LSB]};
   assign duplexFull = modeCtrl[MC_DUPLEX];
   assign anegEnable = modeCtrl[MC_ANEG];
   assign powerDown = modeCtrl[MC_PWR_DOWN];
   assign connLoopback1g = extCtrl2[EC2_CONN_LOOP];
   assign pairSwapOff = bypassCtrl[BYP_PAIR_SWAP_OFF];
   assign rgmiiModeBit = rgmiiCtrl[RG_MODE_BIT];
   assign rxClkDelay = rgmiiCtrl[RG_RX_DLY_LO +: 3];
   assign txClkDelay = rgmiiCtrl[RG_TX_DLY_LO +: 3];
endmodule : ptc_test_ctrl

// File: tb/ptc_mac_model.sv
/* Stand-in MAC and line partner driving both incoming byte streams.
 Assumes the design clock; bytes change every cycle, valid or not. */
`timescale 1ns/1ps
module ptc_mac_model import ptc_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   output ptc_stream_s macTx,
   output ptc_stream_s mediaRx
);
   logic [7:0] cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   // Idle lines keep toggling so stale bytes are never mistaken for data.
   assign macTx = '{valid: en, data: cnt};
   assign mediaRx = '{valid: en, data: ~cnt};
endmodule : ptc_mac_model

// File: tb/ptc_test_monitor.sv
/* Port checker for ptc_test_ctrl.
 Assumes one clock and the active-low asynchronous reset of the top. */
`timescale 1ns/1ps
module ptc_test_monitor import ptc_pkg::*; #(
   parameter int unsigned FRAME_LIMIT = GEN_FRAME_LIMIT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire ptc_stream_s macTx,
   input wire ptc_stream_s mediaRx,
   input wire ptc_stream_s mediaTx,
   input wire ptc_stream_s macRx,
   input wire logic holdInactivePin,
   input wire logic phyActive,
   input wire logic powerDown
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_quiet_idle: assert property ($past(!phyActive || powerDown) |-> !mediaTx.valid && !macRx.valid)
      else $error("stream active while inactive");
   a_hold_pin: assert property (holdInactivePin [*3] |=> !phyActive)
      else $error("active while pin high");
   a_wake_up: assert property (!holdInactivePin [*4] |=> phyActive)
      else $error("inactive while pin low");
   a_rx_source: assert property (macRx.valid |-> macRx == $past(mediaRx) || macRx == $past(macTx))
      else $error("receive byte from no source");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address taken");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
      else $error("read answer wrong");
   a_ar_refused: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
      else $error("second read address taken");
endmodule : ptc_test_monitor
bind ptc_test_ctrl ptc_test_monitor #(.FRAME_LIMIT(FRAME_LIMIT)) i_mon (.clk, .rst_b,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .macTx, .mediaRx,
   .mediaTx, .macRx, .holdInactivePin, .phyActive, .powerDown);

// File: tb/ptc_test_ctrl_bench.sv
/* Self-checking bench for ptc_test_ctrl over AXI4-Lite and byte streams.
 Assumes the stream partner model and a short frame limit. */
`timescale 1ns/1ps
module ptc_test_ctrl_bench import ptc_pkg::*;;
   localparam int unsigned LIM = 3;
   logic clk = 1'b0, rst_b = 1'b0, en = 1'b0, linkUp = 1'b1;
   logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
   logic s_axi_rready = 1, holdInactivePin = 0, rxSymbolErr = 0, phyActive;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic powerDown, anegEnable, connLoopback1g, pairSwapOff, rgmiiModeBit, duplexFull;
   logic [1:0] macMode, speedSel, s_axi_bresp, s_axi_rresp;
   logic [2:0] rxClkDelay, txClkDelay;
   logic [1:0] modes [3] = '{2'b00, 2'b01, 2'b10};
   logic [7:0] firstByte;
   ptc_stream_s macTx, mediaRx, mediaTx, macRx, a, b;
   int bad_count = 0, n_checks = 0, genBytes = 0;
   always #2 clk = ~clk;
   ptc_mac_model i_mac (.clk, .rst_b, .en, .macTx, .mediaRx);
   ptc_test_ctrl #(.FRAME_LIMIT(LIM)) i_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .macTx,
      .mediaRx, .mediaTx, .macRx, .holdInactivePin, .linkUp, .rxSymbolErr, .phyActive,
      .macMode, .speedSel, .duplexFull, .anegEnable, .powerDown, .connLoopback1g,
      .pairSwapOff, .rgmiiModeBit, .rxClkDelay, .txClkDelay);
   always @(posedge clk) begin
      if (mediaTx.valid) begin
         if (genBytes == 0) firstByte = mediaTx.data;
         genBytes++;
      end
   end
   task finish_test;
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 400) begin
         bad_count++;
         finish_test();
      end
   endtask : tick
   task wr(input logic [4:0] r, input logic [15:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= {r, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, AXI_OKAY);
   endtask : wr
   task rd(input logic [4:0] r, output logic [15:0] d);
      int n;
      n = 0;
      s_axi_araddr <= {r, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata[15:0];
      chk(s_axi_rresp, AXI_OKAY);
   endtask : rd
   task rchk(input logic [4:0] r, input logic [15:0] e);
      logic [15:0] d;
      rd(r, d);
      chk(d, e);
   endtask : rchk
   task look;
      @(posedge clk);
      a = mediaRx;
      b = macTx;
      @(posedge clk);
   endtask : look
   initial begin
      logic [15:0] v;
      int n;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(REG_MODE_CTRL, MODE_CTRL_RST);
      rchk(REG_MODE_STAT, MODE_STAT_RST);
      rchk(REG_MODE_STAT, 16'h7804);
      chk({speedSel, anegEnable, duplexFull}, 4'b1010);
      holdInactivePin <= 1'b1;
      repeat (5) @(posedge clk);
      chk(phyActive, 1'b0);
      holdInactivePin <= 1'b0;
      repeat (5) @(posedge clk);
      chk(phyActive, 1'b1);
      for (int i = 0; i < 3; i++) begin
         rd(REG_EXT_CTRL1, v);
         wr(REG_EXT_CTRL1, (v & 16'hE7FF) | {3'b000, modes[i], 11'h000});
         chk(macMode, modes[i]);
      end
      rd(REG_MODE_CTRL, v);
      wr(REG_MODE_CTRL, v | 16'h8000);
      n = 0;
      do begin
         rd(REG_MODE_CTRL, v);
         n++;
      end while (v[15] && n < 200);
      chk(n > 40, 1'b1);
      chk(v, MODE_CTRL_RST);
      chk(macMode, 2'b00);
      wr(REG_EXT_CTRL1, 16'h1000);
      wr(REG_PAGE, PAGE_EXT2);
      wr(REG_RGMII_CTRL, 16'h0053);
      chk({rgmiiModeBit, rxClkDelay, txClkDelay}, 7'h2B);
      rchk(REG_EXT_CTRL1, 16'h0000);
      rchk(REG_RGMII_CTRL, 16'h0053);
      wr(REG_PAGE, PAGE_MAIN);
      rchk(5'h1B, 16'h0000);
      wr(REG_EXT_CTRL2, 16'h0001);
      wr(REG_BYPASS, 16'h0020);
      chk({connLoopback1g, pairSwapOff}, 2'b11);
      for (int i = 0; i < 3; i++) begin
         {rxSymbolErr, linkUp} <= 2'b10;
         @(posedge clk);
         {rxSymbolErr, linkUp} <= 2'b01;
         @(posedge clk);
      end
      rchk(REG_MODE_STAT, 16'h7800);
      rchk(REG_EXT_STAT, 16'h0001);
      rchk(REG_EXT_STAT, 16'h0000);
      rchk(REG_ERR_CNT, 16'h0003);
      rchk(REG_ERR_CNT, 16'h0000);
      en <= 1'b1;
      wr(REG_EXT_CTRL1, 16'h0008);
      look();
      chk({mediaTx, macRx}, {a, a});
      wr(REG_EXT_CTRL1, 16'h0000);
      wr(REG_MODE_CTRL, 16'h5040);
      look();
      chk({mediaTx.valid, macRx}, {1'b0, b});
      wr(REG_MODE_CTRL, 16'h1440);
      look();
      chk({mediaTx, macRx}, {b, 9'h000});
      wr(REG_MODE_CTRL, 16'h1040);
      wr(REG_PAGE, PAGE_EXT1);
      wr(REG_GEN_CFG1, 16'h8102);
      wr(REG_GEN_CFG2, 16'hA504);
      for (int k = 0; k < 2; k++) begin
         genBytes = 0;
         wr(REG_GEN_CFG1, 16'hC102);
         n = 0;
         do begin
            rd(REG_GEN_CFG1, v);
            n++;
         end while (v[14] && n < 300);
         chk({v, macRx.valid}, {16'h8102, 1'b1});
         repeat (20) @(posedge clk);
         chk(genBytes, LIM * 18);
         chk(firstByte, 8'hA5);
      end
      finish_test();
   end
endmodule : ptc_test_ctrl_bench
